// file: verilog/runaway_code_watchdog_pkg.sv
/*
 * Constants, register map and carrier types of the runaway-code watchdog.
 * Assumes a single 125 MHz clock that stands in for the crystal oscillator
 * clock, and a 32-bit AHB-Lite register bus.
 */
package runaway_code_watchdog_pkg;

  // ************************************************************
  // Counter structure
  // ************************************************************
  localparam int PRE_W = 12;
  localparam int CNT_W = 6;
  localparam int CHAIN_W = PRE_W + CNT_W;
  // Prescaler stages 5..12 sit in bits 4..11
  localparam int PRE_CLR_LSB = 4;
  localparam logic [CHAIN_W-1:0] LONG_TIMEOUT_CYC = 18'h3fff0;
  localparam logic [CHAIN_W-1:0] SHORT_TIMEOUT_CYC = 18'h01ff0;
  localparam int POR_CYCLES = 4096;
  localparam int POR_W = 13;
  localparam int RST_PULSE_CYCLES = 32;
  localparam int PULSE_W = 6;

  // ************************************************************
  // Register map (byte addresses, one word per register)
  // ************************************************************
  localparam int ADDR_W = 18;
  localparam logic [15:0] CLEAR_INDEX = 16'hffff;
  localparam logic [ADDR_W-1:0] CLEAR_ADDR = ADDR_W'({CLEAR_INDEX, 2'b00});
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 18'h00000;
  localparam logic [ADDR_W-1:0] MASK_ADDR = 18'h00004;
  localparam logic [ADDR_W-1:0] COUNT_ADDR = 18'h00008;
  localparam int EV_W = 2;
  localparam int EV_WDOG = 0;
  localparam int EV_BADSTOP = 1;
  localparam logic [EV_W-1:0] STATUS_RST = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST = 2'h0;

  // ************************************************************
  // Vector fetch and bus codes
  // ************************************************************
  localparam logic [15:0] RESET_VEC_HI = 16'hfffe;
  localparam logic [15:0] RESET_VEC_LO = 16'hffff;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [4:0] {
    SEL_NONE = 5'h01,
    SEL_STATUS = 5'h02,
    SEL_MASK = 5'h04,
    SEL_COUNT = 5'h08,
    SEL_CLEAR = 5'h10
  } sel_t;

  // CPU core side events, all synchronous to clk
  typedef struct packed {
    logic stopExec;
    logic stopMode;
    logic fetchValid;
    logic [15:0] fetchAddr;
    logic internalReset;
  } cpu_ev_t;

  // Debug qualifiers: mode levels are synchronous, high-voltage detects are pins
  typedef struct packed {
    logic monitorMode;
    logic breakState;
  } dbg_mode_t;

  typedef struct packed {
    logic [1:0] hvIrqSync;
    logic [1:0] hvRstSync;
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic [POR_W-1:0] porCnt;
    logic porDone;
    logic [PULSE_W-1:0] pulseCnt;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    sel_t dpSel;
    logic dpWrite;
    logic [31:0] rdata;
    logic irq;
    logic wdReset;
    logic rstOe;
  } wd_state_t;

endpackage

// file: verilog/runaway_code_watchdog.sv
/*
 * Runaway-code watchdog: prescaler plus counter, timeout reset pulse,
 * AHB-Lite register slave and a sticky-status interrupt line.
 * Assumes clk is the oscillator clock, the CPU event inputs are on clk,
 * and the high-voltage detect levels arrive unsynchronised from pins.
 */
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps

module runaway_code_watchdog #(
  parameter bit LONG_TIMEOUT = 1'b1,
  parameter bit STOP_LEGAL = 1'b1,
  parameter logic [17:0] LONG_CYC = runaway_code_watchdog_pkg::LONG_TIMEOUT_CYC,
  parameter logic [17:0] SHORT_CYC = runaway_code_watchdog_pkg::SHORT_TIMEOUT_CYC
) (
  // Clock, reset, clock enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [runaway_code_watchdog_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // CPU core events and reset vector
  input wire runaway_code_watchdog_pkg::cpu_ev_t cpuEv,
  input wire logic [7:0] resetVectorLow,
  // Debug mode qualifiers and high-voltage detect pins
  input wire runaway_code_watchdog_pkg::dbg_mode_t dbgMode,
  input wire logic hvIrqPinDetect,
  input wire logic hvRstPinDetect,
  // Reset outputs
  output logic wdReset,
  output logic rstPinOut,
  output logic rstPinOe,
  // Reset-cause interrupt line
  output logic irq
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  localparam logic [17:0] LIMIT = LONG_TIMEOUT ? LONG_CYC : SHORT_CYC;

  if (LONG_CYC < 18'h00010 || SHORT_CYC < 18'h00010) begin : g_bad_limit
    $error("timeout must be at least sixteen cycles");
  end

  // ************************************************************
  // State
  // ************************************************************
  runaway_code_watchdog_pkg::wd_state_t s_q;
  runaway_code_watchdog_pkg::wd_state_t s_d;

  logic [runaway_code_watchdog_pkg::CHAIN_W-1:0] chain;
  logic [runaway_code_watchdog_pkg::CHAIN_W-1:0] chainNext;
  logic addrPhase;
  logic disabled;
  logic counting;
  logic overflow;
  logic clearWrite;
  logic preClear;
  logic fullClear;
  logic stopActive;
  logic badStop;
  logic resetVecFetch;
  logic porHit;
  logic [runaway_code_watchdog_pkg::EV_W-1:0] events;
  logic [runaway_code_watchdog_pkg::EV_W-1:0] w1c;
  runaway_code_watchdog_pkg::sel_t sel;

  always_comb begin
    s_d = s_q;

    // Pin-level high-voltage detects; stage 0 feeds only stage 1
    s_d.hvIrqSync = {s_q.hvIrqSync[0], hvIrqPinDetect};
    s_d.hvRstSync = {s_q.hvRstSync[0], hvRstPinDetect};

    // ************************************************************
    // Qualifiers
    // ************************************************************
    disabled = (dbgMode.monitorMode && (s_q.hvIrqSync[1] || s_q.hvRstSync[1]))
      || (dbgMode.breakState && s_q.hvRstSync[1]);
    // With stop illegal the core never halts, so stop mode cannot gate us
    stopActive = STOP_LEGAL && cpuEv.stopMode;
    badStop = !STOP_LEGAL && cpuEv.stopExec;
    // Wait mode is not an input at all: it never stops the count
    counting = !disabled && !stopActive && (s_q.pulseCnt == '0);
    resetVecFetch = cpuEv.fetchValid && (cpuEv.fetchAddr == runaway_code_watchdog_pkg::RESET_VEC_HI
      || cpuEv.fetchAddr == runaway_code_watchdog_pkg::RESET_VEC_LO);

    // ************************************************************
    // Power-on prescaler clear
    // ************************************************************
    porHit = 1'b0;
    if (!s_q.porDone) begin
      if (s_q.porCnt == runaway_code_watchdog_pkg::POR_W'(runaway_code_watchdog_pkg::POR_CYCLES - 1)) begin
        porHit = 1'b1;
        s_d.porDone = 1'b1;
      end else begin
        s_d.porCnt = s_q.porCnt + 1'b1;
      end
    end

    // ************************************************************
    // Bus address phase
    // ************************************************************
    addrPhase = hsel && hready && (htrans == runaway_code_watchdog_pkg::HTRANS_NONSEQ);
    unique case (haddr)
      runaway_code_watchdog_pkg::STATUS_ADDR: sel = runaway_code_watchdog_pkg::SEL_STATUS;
      runaway_code_watchdog_pkg::MASK_ADDR: sel = runaway_code_watchdog_pkg::SEL_MASK;
      runaway_code_watchdog_pkg::COUNT_ADDR: sel = runaway_code_watchdog_pkg::SEL_COUNT;
      runaway_code_watchdog_pkg::CLEAR_ADDR: sel = runaway_code_watchdog_pkg::SEL_CLEAR;
      default: sel = runaway_code_watchdog_pkg::SEL_NONE;
    endcase
    if (addrPhase) begin
      s_d.dpSel = sel;
      s_d.dpWrite = hwrite;
      // Read data is registered here so it stands through the data phase
      unique case (sel)
        runaway_code_watchdog_pkg::SEL_STATUS: s_d.rdata = 32'(s_q.status);
        runaway_code_watchdog_pkg::SEL_MASK: s_d.rdata = 32'(s_q.mask);
        runaway_code_watchdog_pkg::SEL_COUNT: s_d.rdata = 32'({s_q.cnt, s_q.pre});
        runaway_code_watchdog_pkg::SEL_CLEAR: s_d.rdata = 32'(resetVectorLow);
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end else begin
      s_d.dpSel = runaway_code_watchdog_pkg::SEL_NONE;
      s_d.dpWrite = 1'b0;
      s_d.rdata = 32'h0000_0000;
    end

    // ************************************************************
    // Bus data phase writes
    // ************************************************************
    // Any data value, any size, clears; a read never does
    clearWrite = s_q.dpWrite && (s_q.dpSel == runaway_code_watchdog_pkg::SEL_CLEAR);
    w1c = '0;
    if (s_q.dpWrite && s_q.dpSel == runaway_code_watchdog_pkg::SEL_STATUS) begin
      w1c = hwdata[runaway_code_watchdog_pkg::EV_W-1:0];
    end
    if (s_q.dpWrite && s_q.dpSel == runaway_code_watchdog_pkg::SEL_MASK) begin
      s_d.mask = hwdata[runaway_code_watchdog_pkg::EV_W-1:0];
    end

    // ************************************************************
    // Prescaler and counter chain
    // ************************************************************
    chain = {s_q.cnt, s_q.pre};
    chainNext = chain + 1'b1;
    overflow = counting && (chainNext == LIMIT);
    fullClear = cpuEv.internalReset || overflow;
    preClear = porHit || resetVecFetch || (STOP_LEGAL && cpuEv.stopExec);

    if (counting) begin
      s_d.pre = chainNext[runaway_code_watchdog_pkg::PRE_W-1:0];
      s_d.cnt = chainNext[runaway_code_watchdog_pkg::CHAIN_W-1:runaway_code_watchdog_pkg::PRE_W];
    end
    if (clearWrite) begin
      s_d.cnt = '0;
      s_d.pre[runaway_code_watchdog_pkg::PRE_W-1:runaway_code_watchdog_pkg::PRE_CLR_LSB] = '0;
    end
    if (preClear) begin
      s_d.pre = '0;
    end
    if (fullClear) begin
      s_d.pre = '0;
      s_d.cnt = '0;
    end

    // ************************************************************
    // Reset pulse on overflow
    // ************************************************************
    if (overflow) begin
      s_d.pulseCnt = runaway_code_watchdog_pkg::PULSE_W'(runaway_code_watchdog_pkg::RST_PULSE_CYCLES);
    end else if (s_q.pulseCnt != '0) begin
      s_d.pulseCnt = s_q.pulseCnt - 1'b1;
    end
    // Pin and system reset are asserted for exactly the loaded count
    s_d.wdReset = (s_d.pulseCnt != '0);
    s_d.rstOe = (s_d.pulseCnt != '0);

    // ************************************************************
    // Sticky status and interrupt line
    // ************************************************************
    events = '0;
    events[runaway_code_watchdog_pkg::EV_WDOG] = overflow;
    events[runaway_code_watchdog_pkg::EV_BADSTOP] = badStop;
    // Set wins over a clear in the same cycle
    s_d.status = (s_q.status & ~w1c) | events;
    // This line reports the reset cause to a system controller, not the CPU
    s_d.irq = |(s_d.status & s_d.mask);
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{
        hvIrqSync: 2'h0,
        hvRstSync: 2'h0,
        pre: '0,
        cnt: '0,
        porCnt: '0,
        porDone: 1'b0,
        pulseCnt: '0,
        status: runaway_code_watchdog_pkg::STATUS_RST,
        mask: runaway_code_watchdog_pkg::MASK_RST,
        dpSel: runaway_code_watchdog_pkg::SEL_NONE,
        dpWrite: 1'b0,
        rdata: 32'h0000_0000,
        irq: 1'b0,
        wdReset: 1'b0,
        rstOe: 1'b0
      };
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Zero-wait slave: ready and OKAY are tied to constants, not flops
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdReset = s_q.wdReset;
  // Open-drain reset pin only ever pulls low
  assign rstPinOut = 1'b0;
  assign rstPinOe = s_q.rstOe;
  assign irq = s_q.irq;

endmodule

// file: testbench/runaway_code_watchdog_assertions.sv
/* Checker for the watchdog top: reset pulse, vector read, hold-offs.
   Assumes one clock clk and the async active-low reset rstn. */
`timescale 1ns/1ps
module runaway_code_watchdog_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Bus
  input wire logic hsel,
  input wire logic [17:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Core and debug
  input wire runaway_code_watchdog_pkg::cpu_ev_t cpuEv,
  input wire logic [7:0] resetVectorLow,
  input wire runaway_code_watchdog_pkg::dbg_mode_t dbgMode,
  input wire logic hvIrqPinDetect,
  input wire logic hvRstPinDetect,
  // Reset outputs
  input wire logic wdReset,
  input wire logic rstPinOut,
  input wire logic rstPinOe
);
  // ****
  // Run-length counters; the hold counters saturate so a long hold stays armed, hiCnt_q wraps
  // ****
  logic [5:0] hiCnt_q;
  logic [2:0] monCnt_q;
  logic [2:0] brkCnt_q;
  logic [2:0] stopCnt_q;
  function automatic logic [2:0] sat(input logic [2:0] v);
    return (v == 3'h7) ? v : v + 3'h1;
  endfunction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hiCnt_q <= 6'h0;
      monCnt_q <= 3'h0;
      brkCnt_q <= 3'h0;
      stopCnt_q <= 3'h0;
    end else begin
      hiCnt_q <= wdReset ? hiCnt_q + 6'h1 : 6'h0;
      monCnt_q <= (dbgMode.monitorMode && (hvIrqPinDetect || hvRstPinDetect)) ? sat(monCnt_q) : 3'h0;
      brkCnt_q <= (dbgMode.breakState && hvRstPinDetect) ? sat(brkCnt_q) : 3'h0;
      stopCnt_q <= cpuEv.stopMode ? sat(stopCnt_q) : 3'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_pulse_len: assert property ($fell(wdReset) |-> hiCnt_q == 6'h20)
    else $error("reset pulse not 32 cycles");
  a_pin_follow: assert property (rstPinOe == wdReset)
    else $error("pin enable differs from reset");
  a_pin_low: assert property (rstPinOut == 1'b0)
    else $error("reset pin not driven low");
  a_vector_read: assert property ((ce && hsel && hready && !hwrite && htrans == 2'h2
    && haddr == runaway_code_watchdog_pkg::CLEAR_ADDR) |=> hrdata == {24'h0, $past(resetVectorLow)})
    else $error("clear location read wrong");
  a_rest_after: assert property ($fell(wdReset) |-> !wdReset [*8])
    else $error("reset again right after pulse");
  a_monitor_hold: assert property (monCnt_q >= 3'h5 |-> !$rose(wdReset))
    else $error("reset in monitor hold");
  a_break_hold: assert property (brkCnt_q >= 3'h5 |-> !$rose(wdReset))
    else $error("reset in break hold");
  a_stop_hold: assert property (stopCnt_q >= 3'h5 |-> !$rose(wdReset))
    else $error("reset in stop mode");
endmodule
bind runaway_code_watchdog runaway_code_watchdog_assertions runaway_code_watchdog_assertions_i (
  .clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .cpuEv(cpuEv),
  .resetVectorLow(resetVectorLow), .dbgMode(dbgMode), .hvIrqPinDetect(hvIrqPinDetect),
  .hvRstPinDetect(hvRstPinDetect), .wdReset(wdReset), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe));

// file: testbench/cpu_core_model.sv
/* CPU core model: AHB-Lite master and core event pulses.
   Assumes a zero-or-more wait-state slave whose hreadyout is hready. */
`timescale 1ns/1ps
module cpu_core_model (
  // Clock and answer
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Request
  output logic [17:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Core events
  output runaway_code_watchdog_pkg::cpu_ev_t cpuEv
);
  logic [31:0] rdCap;
  initial begin
    haddr = 18'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cpuEv = '0;
  end
  always @(posedge clk) rdCap <= hrdata;
  // Clearing writes come from the main sequence only
  task automatic xfer(input logic wr, input logic [17:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    haddr <= a;
    htrans <= runaway_code_watchdog_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    // Released data bus must not look like the last value
    hwdata <= ~d;
    #1 q = rdCap;
  endtask
  // One-cycle event; stop mode level stays as given
  task automatic core_event(input runaway_code_watchdog_pkg::cpu_ev_t ev);
    runaway_code_watchdog_pkg::cpu_ev_t lvl;
    lvl = '0;
    lvl.stopMode = ev.stopMode;
    @(posedge clk);
    cpuEv <= ev;
    @(posedge clk);
    cpuEv <= lvl;
  endtask
endmodule

// file: testbench/runaway_code_watchdog_tb.sv
/* Self-checking bench of the watchdog with a shortened timeout.
   Assumes the core model as bus master and a 125 MHz clock. */
`timescale 1ns/1ps
module runaway_code_watchdog_tb;
  localparam int LIM = 64;
  localparam logic [17:0] CLR = runaway_code_watchdog_pkg::CLEAR_ADDR;
  localparam logic [17:0] STS = runaway_code_watchdog_pkg::STATUS_ADDR;
  localparam logic [17:0] MSK = runaway_code_watchdog_pkg::MASK_ADDR;
  localparam logic [17:0] CNT = runaway_code_watchdog_pkg::COUNT_ADDR;
  logic clk, rstn, ce, hvIrqPinDetect, hvRstPinDetect, seenRst;
  logic [7:0] vec;
  logic [17:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hwrite, hreadyout, hresp, wdReset, rstPinOut, rstPinOe, irq;
  logic [31:0] hwdata, hrdata, q;
  runaway_code_watchdog_pkg::dbg_mode_t dbgMode;
  runaway_code_watchdog_pkg::cpu_ev_t cpuEv, ev;
  int errorCnt, totalChecks, n;
  time t0;
  runaway_code_watchdog #(.LONG_CYC(18'(LIM)), .SHORT_CYC(18'(LIM))) runaway_code_watchdog_i (
    .clk(clk), .rstn(rstn), .ce(ce), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpuEv(cpuEv), .resetVectorLow(vec),
    .dbgMode(dbgMode), .hvIrqPinDetect(hvIrqPinDetect), .hvRstPinDetect(hvRstPinDetect),
    .wdReset(wdReset), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .irq(irq));
  cpu_core_model cpu_core_model_i (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .cpuEv(cpuEv));
  always @(negedge clk) if (wdReset === 1'b1) seenRst = 1'b1;
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    logic [31:0] x;
    cpu_core_model_i.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [17:0] a, output logic [31:0] d);
    cpu_core_model_i.xfer(1'b0, a, 32'h0, d);
  endtask
  task automatic wait_rst();
    for (int i = 0; i < 300 && wdReset !== 1'b1; i++) @(negedge clk);
  endtask
  // Lets any pulse end, then starts a fresh period
  task automatic settle();
    for (int i = 0; i < 99 && wdReset !== 1'b0; i++) @(negedge clk);
    wr(CLR, 32'h0);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_timeout();
    settle();
    wr(MSK, 32'h0);
    wr(STS, 32'h3);
    rd(STS, q);
    chk("status", 32'h0, q);
    wr(CLR, 32'ha5);
    t0 = $time;
    repeat (4) rd(CLR, q);
    chk("vector byte", {24'h0, vec}, q);
    wait_rst();
    chk("timeout", 32'h1, 32'((($time - t0) / 8) inside {[LIM - 17 : LIM + 3]}));
    n = 0;
    while (wdReset === 1'b1 && n < 99) begin
      @(negedge clk);
      n++;
    end
    chk("pulse", 32'h20, n);
    rd(STS, q);
    chk("cause", 32'h1, q);
    chk("irq masked", 32'h0, irq);
    wr(MSK, 32'h1);
    rd(MSK, q);
    chk("mask", 32'h1, q);
    chk("irq", 32'h1, irq);
    wr(STS, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq cleared", 32'h0, irq);
    rd(18'h00100, q);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_hold();
    for (int k = 0; k < 4; k++) begin
      settle();
      seenRst = 1'b0;
      ev = '0;
      ev.stopExec = (k == 2);
      ev.stopMode = (k == 2);
      cpu_core_model_i.core_event(ev);
      dbgMode <= '{monitorMode: k == 0, breakState: k == 1 || k == 3};
      hvIrqPinDetect <= (k == 0 || k == 3);
      hvRstPinDetect <= (k == 1);
      repeat (200) @(posedge clk);
      chk("fired in hold", 32'(k == 3), seenRst);
      dbgMode <= '0;
      hvIrqPinDetect <= 1'b0;
      hvRstPinDetect <= 1'b0;
      cpu_core_model_i.core_event('0);
    end
  endtask
  task automatic t_fetch();
    for (int k = 0; k < 2; k++) begin
      settle();
      // Stay well inside the period: the clear leaves up to 15 low prescaler counts
      repeat (24) @(posedge clk);
      ev = '0;
      ev.fetchValid = (k == 0);
      ev.fetchAddr = runaway_code_watchdog_pkg::RESET_VEC_HI;
      ev.internalReset = (k == 1);
      cpu_core_model_i.core_event(ev);
      rd(CNT, q);
      chk("chain after clear", 32'h1, 32'(q[17:0] < 18'h8));
    end
  endtask
  task automatic completeRun();
    $display("Checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    errorCnt++;
    completeRun();
  end
  initial begin
    {rstn, hvIrqPinDetect, hvRstPinDetect, seenRst} = 4'h0;
    ce = 1'b1;
    dbgMode = '0;
    vec = 8'h5a;
    errorCnt = 0;
    totalChecks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    settle();
    t_timeout();
    t_hold();
    t_fetch();
    completeRun();
  end
endmodule
